// ==== pkg/wdt_pkg.sv ====
`default_nettype none

package wdt_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned TIMEOUT_MS      = 1600;
   localparam longint unsigned TIMEOUT_CYC =
      (longint'(CLK_HZ) * longint'(TIMEOUT_MS)) / 64'h3E8;
   // floating detect: kick must sit in the undriven state this long
   localparam int unsigned FLOAT_US        = 10;
   localparam int unsigned FLOAT_CYC       = (CLK_HZ / 1_000_000) * FLOAT_US;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CNT_W           = 32;
   localparam int unsigned SYNC_W          = 3;
   localparam logic        KICK_RST        = 1'h0;
   localparam logic        TIMEOUT_N_RST   = 1'h1;

   typedef enum logic [1:0] {
      WD_DISABLED = 2'b00,
      WD_TIMING   = 2'b01,
      WD_EXPIRED  = 2'b10
   } wd_state_t;

endpackage

`default_nettype wire

// ==== hdl/kick_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module kick_sync #(
   parameter int unsigned WIDTH = wdt_pkg::SYNC_W
) (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic async_in,
   output logic      level_out,
   output logic      edge_pulse
);

   // ----------------------------------------------------------------
   // three-stage synchroniser; stage 0 read only by stage 1
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;
   logic             level_reg;
   logic             level_next;

   always_comb begin
      sync_next = {sync_reg[WIDTH-2:0], async_in};
      level_next = level_reg;
      // change counts once the last two stages agree
      if (sync_reg[WIDTH-1] == sync_reg[WIDTH-2]) begin
         level_next = sync_reg[WIDTH-1];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync_reg  <= {WIDTH{wdt_pkg::KICK_RST}};
         level_reg <= wdt_pkg::KICK_RST;
      end else begin
         sync_reg  <= sync_next;
         level_reg <= level_next;
      end
   end

   assign level_out  = level_reg;
   assign edge_pulse = level_next != level_reg;

endmodule

`default_nettype wire

// ==== hdl/supervisor_watchdog_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module supervisor_watchdog_timer #(
   parameter longint unsigned TIMEOUT_CYCLES = wdt_pkg::TIMEOUT_CYC,
   parameter int unsigned     FLOAT_CYCLES   = wdt_pkg::FLOAT_CYC
) (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic watchdog_kick_in,
   input  wire logic kick_undriven_in,
   input  wire logic supply_low,
   input  wire logic supervisor_reset_active,
   output logic      watchdog_timeout_n
);

   localparam int unsigned W = wdt_pkg::CNT_W;
   localparam logic [W-1:0] TERM = W'(TIMEOUT_CYCLES - 1);
   localparam logic [W-1:0] FTERM = W'(FLOAT_CYCLES - 1);

   // ----------------------------------------------------------------
   // input conditioning
   // ----------------------------------------------------------------
   logic kick_edge;
   logic undriven_lvl;

   kick_sync #(.WIDTH(wdt_pkg::SYNC_W)) u_kick (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .async_in   (watchdog_kick_in),
      .level_out  (),
      .edge_pulse (kick_edge)
   );

   kick_sync #(.WIDTH(wdt_pkg::SYNC_W)) u_float (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .async_in   (kick_undriven_in),
      .level_out  (undriven_lvl),
      .edge_pulse ()
   );

   // ----------------------------------------------------------------
   // floating detect
   // ----------------------------------------------------------------
   logic [W-1:0] fcnt_reg;
   logic [W-1:0] fcnt_next;
   logic         floating;

   // undriven must persist to disable, so a slow mid-level swing of a
   // real toggle does not drop the watchdog
   assign floating = undriven_lvl && (fcnt_reg == FTERM);

   always_comb begin
      fcnt_next = fcnt_reg;
      if (!undriven_lvl) begin
         fcnt_next = '0;
      end else if (fcnt_reg != FTERM) begin
         fcnt_next = fcnt_reg + W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fcnt_reg <= '0;
      end else begin
         fcnt_reg <= fcnt_next;
      end
   end

   // ----------------------------------------------------------------
   // timer control terms
   // ----------------------------------------------------------------
   wdt_pkg::wd_state_t state_reg;
   wdt_pkg::wd_state_t state_next;
   logic [W-1:0]       cnt_reg;
   logic [W-1:0]       cnt_next;
   logic               timer_hold;
   logic               timer_done;
   logic               timer_kick;

   // reset and floating both park the timer, so a kick then does nothing
   assign timer_hold = supervisor_reset_active || floating;
   assign timer_done = (cnt_reg == TERM);
   assign timer_kick = kick_edge && !timer_hold;

   // ----------------------------------------------------------------
   // timeout counter
   // ----------------------------------------------------------------
   // the counter parks at its terminal value, so an expired timer never wraps
   always_comb begin
      cnt_next = cnt_reg;
      case (state_reg)
         wdt_pkg::WD_DISABLED: begin
            cnt_next = '0;
         end
         wdt_pkg::WD_TIMING: begin
            if (!timer_done) begin
               cnt_next = cnt_reg + W'(1);
            end
         end
         wdt_pkg::WD_EXPIRED: begin
            cnt_next = cnt_reg;
         end
         default: begin
            cnt_next = '0;
         end
      endcase
      if (timer_kick) begin
         cnt_next = '0;
      end
      if (timer_hold) begin
         cnt_next = '0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // watchdog state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         wdt_pkg::WD_DISABLED: begin
            if (!timer_hold) begin
               state_next = wdt_pkg::WD_TIMING;
            end
         end
         wdt_pkg::WD_TIMING: begin
            if (timer_done && !timer_kick) begin
               state_next = wdt_pkg::WD_EXPIRED;
            end
         end
         wdt_pkg::WD_EXPIRED: begin
            if (timer_kick) begin
               state_next = wdt_pkg::WD_TIMING;
            end
         end
         default: begin
            state_next = wdt_pkg::WD_DISABLED;
         end
      endcase
      if (timer_hold) begin
         state_next = wdt_pkg::WD_DISABLED;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= wdt_pkg::WD_DISABLED;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // output
   // ----------------------------------------------------------------
   logic out_reg;
   logic out_next;
   logic release_now;

   // supply_low is on-chip and same-clock, so it goes through out_reg and pulls the output low one clock later
   always_comb begin
      case (state_next)
         wdt_pkg::WD_EXPIRED: begin
            out_next = 1'h0;
         end
         wdt_pkg::WD_DISABLED: begin
            out_next = 1'h1;
         end
         wdt_pkg::WD_TIMING: begin
            out_next = 1'h1;
         end
         default: begin
            out_next = 1'h1;
         end
      endcase
      if (supply_low) begin
         out_next = 1'h0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_reg <= wdt_pkg::TIMEOUT_N_RST;
      end else begin
         out_reg <= out_next;
      end
   end

   // low-supply release is combinational so the output rises at once
   // an expired timer keeps out_next low, so only a healthy timer releases early
   assign release_now        = !supply_low && out_next;
   assign watchdog_timeout_n = out_reg || release_now;

endmodule

`default_nettype wire

// ==== dv/kick_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module kick_partner (
   input wire logic core_clk,
   input wire logic run,
   input wire logic float_en,
   input wire logic [7:0] half_period,
   output logic kick_out = 1'h0,
   output logic undriven_out = 1'h0
);
   int cnt = 0;
   // stall is run low; a released pin toggles, never keeps its last level
   always @(posedge core_clk) begin
      #1;
      undriven_out = float_en;
      kick_out = kick_out ^ (float_en || (run && cnt + 1 >= half_period));
      cnt = (run && cnt + 1 < half_period) ? cnt + 1 : 0;
   end
endmodule
`default_nettype wire

// ==== dv/supervisor_watchdog_timer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_timer_checker #(
   parameter longint unsigned TIMEOUT_CYCLES = 50
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic watchdog_kick_in,
   input wire logic kick_undriven_in,
   input wire logic supply_low,
   input wire logic supervisor_reset_active,
   input wire logic watchdog_timeout_n
);
   logic [31:0] quiet_reg, quiet_next;
   logic        kick_reg;
   // idle at the pin; the synchroniser lags, so the checks leave slack
   always_comb quiet_next = (watchdog_kick_in != kick_reg || supervisor_reset_active
      || kick_undriven_in) ? 32'h0 : quiet_reg + 32'h1;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         quiet_reg <= 32'h0;
         kick_reg <= 1'h0;
      end else begin
         quiet_reg <= quiet_next;
         kick_reg <= watchdog_kick_in;
      end
   end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_calm;
      !supply_low && quiet_reg > 32'hA;
   endsequence
   a_low_forces: assert property (supply_low [*2] |-> !watchdog_timeout_n)
      else $error("forced");
   a_reset_clears: assert property ((supervisor_reset_active && !supply_low) [*2]
      |-> watchdog_timeout_n) else $error("reset");
   a_float_off: assert property ((kick_undriven_in && !supply_low) [*8]
      |-> watchdog_timeout_n) else $error("float");
   a_no_early: assert property ($fell(watchdog_timeout_n) |-> supply_low
      || $past(supply_low) || quiet_reg >= TIMEOUT_CYCLES) else $error("early");
   a_times_out: assert property (quiet_reg == TIMEOUT_CYCLES + 10
      |-> !watchdog_timeout_n) else $error("late");
   a_stays_low: assert property (!watchdog_timeout_n ##0 s_calm ##1 s_calm
      |-> !watchdog_timeout_n) else $error("hold");
   a_quick_release: assert property ($fell(supply_low) && quiet_reg > 32'hA
      && quiet_reg < TIMEOUT_CYCLES |-> watchdog_timeout_n) else $error("release");
   a_kick_clears: assert property (!watchdog_timeout_n && $changed(watchdog_kick_in)
      ##1 (!supply_low) [*6] |-> watchdog_timeout_n) else $error("kick");
endmodule
bind supervisor_watchdog_timer supervisor_watchdog_timer_checker #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) checker_inst (.core_clk(core_clk), .resetn(resetn),
   .watchdog_kick_in(watchdog_kick_in), .kick_undriven_in(kick_undriven_in),
   .supply_low(supply_low), .supervisor_reset_active(supervisor_reset_active),
   .watchdog_timeout_n(watchdog_timeout_n));
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int TO = 50;
   logic core_clk = 1'h0, resetn = 1'h0, supply_low = 1'h0, rst_act = 1'h0;
   logic run = 1'h0, flt = 1'h0, sup_q = 1'h0, kick_q = 1'h0;
   logic [7:0] half = 8'h0A;
   logic [31:0] seed = 32'h0000F55C;
   wire logic kick, undriven, tmo_n;
   int mismatches = 0, checked = 0, idle = 0, held = 0;
   int plan [11][5] = '{'{150,1,0,0,0}, '{20,1,1,0,0}, '{80,0,0,0,0}, '{20,0,1,0,0},
      '{20,0,0,0,0}, '{40,1,0,0,0}, '{80,0,0,1,0}, '{80,0,0,0,0}, '{80,0,0,0,1},
      '{20,0,1,0,1}, '{20,0,0,0,1}};
   always #12.5 core_clk = ~core_clk;
   kick_partner kick_partner_inst (.core_clk(core_clk), .run(run), .float_en(flt),
      .half_period(half), .kick_out(kick), .undriven_out(undriven));
   supervisor_watchdog_timer #(.TIMEOUT_CYCLES(TO), .FLOAT_CYCLES(2))
      supervisor_watchdog_timer_inst (.core_clk(core_clk), .resetn(resetn),
      .watchdog_kick_in(kick), .kick_undriven_in(undriven), .supply_low(supply_low),
      .supervisor_reset_active(rst_act), .watchdog_timeout_n(tmo_n));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input string name, input logic seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // model counts at the pins; cycles near the limit are left unjudged
   always @(posedge core_clk) begin
      idle <= (kick != kick_q || rst_act || undriven) ? 0 : idle + 1;
      held <= (rst_act || undriven) ? held + 1 : 0;
      kick_q <= kick;
      sup_q <= supply_low;
   end
   always @(negedge core_clk) begin
      if (resetn && supply_low && sup_q) begin
         check("forced", tmo_n, 1'h0);
      end else if (resetn && idle > TO + 10) begin
         check("expired", tmo_n, 1'h0);
      end else if (resetn && !supply_low && (held > 11 || (idle > 9 && idle < TO))) begin
         check("alive", tmo_n, 1'h1);
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      #1 resetn = 1'h1;
      repeat (6) begin
         seed = xorshift(seed);
         half = 8'h02 + {3'h0, seed[4:0]};
         foreach (plan[k]) begin
            @(posedge core_clk);
            #1 {run, supply_low} = {plan[k][1][0], plan[k][2][0]};
            {rst_act, flt} = {plan[k][3][0], plan[k][4][0]};
            repeat (plan[k][0]) @(posedge core_clk);
         end
      end
      report_and_stop();
   end
   initial begin
      #250000;
      mismatches++;
      report_and_stop();
   end
endmodule
`default_nettype wire
